// File: verilog/rsel_consts.svh
/*
  Constants of the reference input selection block: register offsets,
  field positions, reset values and monitor limits.
  Assumes inclusion by bare name from the design files.
*/
// Overview of operation
// - input A monitor uses divided clock
// - input B monitor uses divided clock
// - divider binary ratio, reset divide one
// - dividers reach monitors only on commit
// - gate clear: both inputs routed, monitored
// - gate set: unselected input blocked, unmonitored
// - internal enable only when external config 10
// - enable zero: external holdover, no expiry
// - mode field honoured only when enabled
// - manual modes follow reference-select bit
// - automatic modes choose by loss state
// - mode encodings 00,01,10,11; reset 00
// - revertive bit ignored when mode low zero
// - revertive off: keep selection on recovery
// - revertive on: return to primary input
// - hold-off countdown after loss, then fail-over
// - hold-off counter reloads at each zero
`ifndef RSEL_CONSTS_SVH
`define RSEL_CONSTS_SVH

`define RSEL_OFS_GATING 8'h20
`define RSEL_OFS_MODE 8'h21
`define RSEL_OFS_HOLDOFF 8'h22
`define RSEL_OFS_HOLDDIV 8'h23
`define RSEL_OFS_DIVA_LO 8'h44
`define RSEL_OFS_DIVA_HI 8'h45
`define RSEL_OFS_DIVB_LO 8'h46
`define RSEL_OFS_DIVB_HI 8'h47

`define RSEL_BIT_ENABLE 0
`define RSEL_BIT_BLOCK 2
`define RSEL_BIT_REFSEL 0
`define RSEL_POS_MODE 2
`define RSEL_BIT_REVERTIVE_SWITCH 4
`define RSEL_POS_HOLDDIV 6

`define RSEL_RST_DIV 15'h0001
`define RSEL_RST_HOLDOFF 8'h80
`define RSEL_RST_HOLDDIV 2'h2
`define RSEL_RST_MODE 2'h0
`define RSEL_EXT_INTERNAL 2'h2

// divided ticks without an input edge before loss is flagged
`define RSEL_MISS_LIMIT 2'h2
// hold-off prescaler limit at divider 3, shifted down for smaller dividers, 2^(15+divider) clocks per step
`define RSEL_PRE_MAX 18'h3FFFF

`endif

// File: verilog/rsel_pkg.sv
/*
  Types of the reference input selection block.
  Assumes rsel_consts.svh supplies the numeric constants.
*/
package rsel_pkg;
  typedef enum logic {RSEL_IN_A, RSEL_IN_B} rsel_input_type;
  typedef enum logic [1:0] {
    RSEL_MANUAL_HOLD = 2'h0,
    RSEL_AUTO_NOHOLD = 2'h1,
    RSEL_SHORT_HOLD = 2'h2,
    RSEL_AUTO_HOLD = 2'h3
  } rsel_mode_type;
endpackage

// File: verilog/rsel_activity_monitor.sv
/*
  Activity monitor of one reference input: compares input edges with
  the system clock divided by the programmed ratio.
  Assumes the reference level is sampled synchronously to clk_sys.
*/
`timescale 1ns/1ps
`include "rsel_consts.svh"
module rsel_activity_monitor (
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  input wire logic refIn, // sampled reference level
  input wire logic monEnable, // monitoring allowed
  input wire logic [14:0] divRatio, // committed divide ratio
  output logic inputLost // loss-of-signal status
);
  logic refPrev;
  logic [14:0] divCnt;
  logic edgeSeen;
  logic [1:0] missCnt;
  wire refEdge = refIn & ~refPrev;
  // ratio zero behaves as divide by one
  wire [14:0] divLast = (divRatio == 15'h0000) ? 15'h0000 : divRatio - 15'h0001;
  wire divTick = (divCnt >= divLast);

  always_ff @(posedge clk_sys) begin
    refPrev <= srst ? 1'b0 : refIn;
  end

  always_ff @(posedge clk_sys) begin
    if (srst || !monEnable || divTick) begin
      divCnt <= 15'h0000;
    end else begin
      divCnt <= divCnt + 15'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || !monEnable) begin
      edgeSeen <= 1'b0;
      missCnt <= 2'h0;
    end else if (divTick) begin
      edgeSeen <= refEdge;
      missCnt <= (edgeSeen || refEdge) ? 2'h0 :
        ((missCnt == `RSEL_MISS_LIMIT) ? missCnt : missCnt + 2'h1);
    end else if (refEdge) begin
      edgeSeen <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inputLost <= 1'b0;
    end else if (monEnable) begin
      inputLost <= (missCnt == `RSEL_MISS_LIMIT) && !edgeSeen && !refEdge;
    end
  end
endmodule // rsel_activity_monitor

// File: verilog/rsel_reference_select.sv
/*
  Reference input selection: configuration registers, two activity
  monitors, input gating, manual/automatic selection and hold-off.
  Assumes a serial-port front end delivers byte register accesses and
  a commit strobe; reference levels are synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "rsel_consts.svh"
module rsel_reference_select (
  input wire logic clk_sys, // system (oscillator) clock
  input wire logic srst, // synchronous reset
  input wire logic [7:0] regAddr, // register address
  input wire logic [7:0] regWrData, // write data
  input wire logic regWrEn, // write strobe
  output logic [7:0] regRdData, // read data, registered
  input wire logic commitStrobe, // double-buffer commit
  input wire logic [1:0] extSelCfg, // external selection configuration
  input wire logic refA, // reference input A
  input wire logic refB, // reference input B
  output logic pllRef, // selected reference to PLL
  output logic refAEn, // input A routed
  output logic refBEn, // input B routed
  output rsel_pkg::rsel_input_type curSel, // current reference
  output logic losA, // input A lost
  output logic losB, // input B lost
  output logic holdover, // holdover active
  output logic holdoffExpired // hold-off expiry pulse
);
  import rsel_pkg::*;

  logic inBlock, enInt, intSel, revertive_switch;
  rsel_mode_type selMode;
  logic [7:0] holdPeriod;
  logic [1:0] holdDiv;
  logic [14:0] shadowDivA, shadowDivB, activeDivA, activeDivB;
  logic [17:0] preCnt;
  logic [7:0] holdCnt;
  rsel_input_type next_curSel;

  wire wrGate = regWrEn && (regAddr == `RSEL_OFS_GATING);
  wire wrMode = regWrEn && (regAddr == `RSEL_OFS_MODE);
  wire wrHold = regWrEn && (regAddr == `RSEL_OFS_HOLDOFF);
  wire wrHDiv = regWrEn && (regAddr == `RSEL_OFS_HOLDDIV);
  wire wrALo = regWrEn && (regAddr == `RSEL_OFS_DIVA_LO);
  wire wrAHi = regWrEn && (regAddr == `RSEL_OFS_DIVA_HI);
  wire wrBLo = regWrEn && (regAddr == `RSEL_OFS_DIVB_LO);
  wire wrBHi = regWrEn && (regAddr == `RSEL_OFS_DIVB_HI);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inBlock <= 1'b0;
      enInt <= 1'b0;
      revertive_switch <= 1'b0;
      selMode <= rsel_mode_type'(`RSEL_RST_MODE);
      intSel <= 1'b0;
      holdPeriod <= `RSEL_RST_HOLDOFF;
      holdDiv <= `RSEL_RST_HOLDDIV;
    end else begin
      if (wrGate) begin
        inBlock <= regWrData[`RSEL_BIT_BLOCK];
        enInt <= regWrData[`RSEL_BIT_ENABLE];
      end
      if (wrMode) begin
        revertive_switch <= regWrData[`RSEL_BIT_REVERTIVE_SWITCH];
        selMode <= rsel_mode_type'(regWrData[`RSEL_POS_MODE +: 2]);
        intSel <= regWrData[`RSEL_BIT_REFSEL];
      end
      if (wrHold) begin
        holdPeriod <= regWrData;
      end
      if (wrHDiv) begin
        holdDiv <= regWrData[`RSEL_POS_HOLDDIV +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shadowDivA <= `RSEL_RST_DIV;
      shadowDivB <= `RSEL_RST_DIV;
    end else begin
      if (wrALo) shadowDivA[7:0] <= regWrData;
      if (wrAHi) shadowDivA[14:8] <= regWrData[6:0];
      if (wrBLo) shadowDivB[7:0] <= regWrData;
      if (wrBHi) shadowDivB[14:8] <= regWrData[6:0];
    end
  end

  // monitors see dividers only after commit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      activeDivA <= `RSEL_RST_DIV;
      activeDivB <= `RSEL_RST_DIV;
    end else if (commitStrobe) begin
      activeDivA <= shadowDivA;
      activeDivB <= shadowDivB;
    end
  end

  // readback shows the written (shadow) divider values
  logic [7:0] rdMux;
  always_comb begin
    unique case (regAddr)
      `RSEL_OFS_GATING: rdMux = {5'h00, inBlock, 1'b0, enInt};
      `RSEL_OFS_MODE: rdMux = {3'h0, revertive_switch, selMode, 1'b0, intSel};
      `RSEL_OFS_HOLDOFF: rdMux = holdPeriod;
      `RSEL_OFS_HOLDDIV: rdMux = {holdDiv, 6'h00};
      `RSEL_OFS_DIVA_LO: rdMux = shadowDivA[7:0];
      `RSEL_OFS_DIVA_HI: rdMux = {1'b0, shadowDivA[14:8]};
      `RSEL_OFS_DIVB_LO: rdMux = shadowDivB[7:0];
      `RSEL_OFS_DIVB_HI: rdMux = {1'b0, shadowDivB[14:8]};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    regRdData <= srst ? 8'h00 : rdMux;
  end

  // unselected input blocked when gate set
  assign refAEn = !inBlock || (curSel == RSEL_IN_A);
  assign refBEn = !inBlock || (curSel == RSEL_IN_B);

  rsel_activity_monitor monA (
    .clk_sys(clk_sys),
    .srst(srst),
    .refIn(refA),
    .monEnable(refAEn),
    .divRatio(activeDivA),
    .inputLost(losA)
  );

  rsel_activity_monitor monB (
    .clk_sys(clk_sys),
    .srst(srst),
    .refIn(refB),
    .monEnable(refBEn),
    .divRatio(activeDivB),
    .inputLost(losB)
  );

  // enable valid only in internal config
  wire cfgInternal = (extSelCfg == `RSEL_EXT_INTERNAL);
  // mode field needs config and enable
  wire modeActive = cfgInternal && enInt;
  // low mode bit marks the automatic modes
  wire autoMode = modeActive && selMode[0];
  wire holdMode = modeActive && (selMode == RSEL_SHORT_HOLD || selMode == RSEL_AUTO_HOLD);
  rsel_input_type primary, other;
  assign primary = intSel ? RSEL_IN_B : RSEL_IN_A;
  assign other = (curSel == RSEL_IN_A) ? RSEL_IN_B : RSEL_IN_A;
  wire curLos = (curSel == RSEL_IN_A) ? losA : losB;
  wire otherLos = (curSel == RSEL_IN_A) ? losB : losA;
  wire primLos = intSel ? losB : losA;

  // hold-off prescaler: 2^(15+divider) clocks per step
  wire holdCounting = holdMode && curLos;
  wire [17:0] preLimit = `RSEL_PRE_MAX >> (2'h3 - holdDiv);
  wire preTick = (preCnt == preLimit);
  always_ff @(posedge clk_sys) begin
    if (srst || !holdCounting || preTick) begin
      preCnt <= 18'h00000;
    end else begin
      preCnt <= preCnt + 18'h00001;
    end
  end

  wire holdZero = holdCounting && preTick && (holdCnt == 8'h00);
  always_ff @(posedge clk_sys) begin
    if (srst || !holdCounting || holdZero) begin
      holdCnt <= holdPeriod;
    end else if (preTick) begin
      holdCnt <= holdCnt - 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    holdoffExpired <= srst ? 1'b0 : holdZero;
  end

  wire failNow = curLos && !otherLos &&
    (selMode == RSEL_AUTO_NOHOLD || holdZero);
  wire revertNow = revertive_switch && (curSel != primary) && !primLos;

  always_comb begin
    next_curSel = curSel;
    // external holdover and manual follow the select bit
    if (!autoMode) begin
      next_curSel = primary;
    end else if (failNow) begin
      next_curSel = other;
    end else if (revertNow) begin
      next_curSel = primary;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      curSel <= RSEL_IN_A;
    end else begin
      curSel <= next_curSel;
    end
  end

  // no expiry counter in external holdover
  always_ff @(posedge clk_sys) begin
    holdover <= srst ? 1'b0 :
      (cfgInternal && curLos && (!enInt || selMode != RSEL_AUTO_NOHOLD));
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pllRef <= 1'b0;
    end else begin
      pllRef <= (curSel == RSEL_IN_A) ? (refA & refAEn) : (refB & refBEn);
    end
  end

  chk_div_reset: assert property (@(posedge clk_sys)
    $fell(srst) |-> activeDivA == 15'h0001 && activeDivB == 15'h0001)
    else $error("monitor dividers not one after reset");

  chk_commit_only: assert property (@(posedge clk_sys) disable iff (srst)
    !commitStrobe |=> activeDivA == $past(activeDivA) && activeDivB == $past(activeDivB))
    else $error("divider changed without commit");

  chk_gate_clear: assert property (@(posedge clk_sys) disable iff (srst)
    !inBlock |-> refAEn && refBEn)
    else $error("input gated while gate clear");

  chk_gate_set: assert property (@(posedge clk_sys) disable iff (srst)
    inBlock |-> (refAEn != refBEn) && (refAEn == (curSel == RSEL_IN_A)))
    else $error("wrong input gated");

  chk_ext_ignore: assert property (@(posedge clk_sys) disable iff (srst)
    !cfgInternal |=> curSel == ($past(intSel) ? RSEL_IN_B : RSEL_IN_A))
    else $error("selection left select bit outside internal config");

  chk_manual_select: assert property (@(posedge clk_sys) disable iff (srst)
    modeActive && !selMode[0] ##1 modeActive && !selMode[0]
      |-> curSel == ($past(intSel) ? RSEL_IN_B : RSEL_IN_A))
    else $error("manual mode did not follow select bit");

  chk_auto_fail: assert property (@(posedge clk_sys) disable iff (srst)
    autoMode && selMode == RSEL_AUTO_NOHOLD && curLos && !otherLos |=> curSel != $past(curSel))
    else $error("no fail-over in automatic mode");

  chk_no_revert: assert property (@(posedge clk_sys) disable iff (srst)
    autoMode && !revertive_switch && !curLos |=> curSel == $past(curSel))
    else $error("selection moved without revertive switching");

  chk_revert: assert property (@(posedge clk_sys) disable iff (srst)
    autoMode && revertNow && !failNow |=> curSel == $past(primary))
    else $error("no return to primary");

  chk_holdoff_reload: assert property (@(posedge clk_sys) disable iff (srst)
    holdZero |=> holdoffExpired && (!holdCounting || holdCnt == $past(holdPeriod)))
    else $error("hold-off counter not reloaded at zero");

  chk_block_freeze: assert property (@(posedge clk_sys) disable iff (srst)
    (!refAEn |=> $stable(losA)) and (!refBEn |=> $stable(losB)))
    else $error("blocked input monitor not frozen");

  chk_ext_holdover: assert property (@(posedge clk_sys) disable iff (srst)
    !enInt |=> !holdoffExpired)
    else $error("expiry counter ran with internal control off");

  chk_mode_ignored: assert property (@(posedge clk_sys) disable iff (srst)
    !modeActive |=> curSel == $past(primary))
    else $error("mode field honoured while not enabled");

  chk_revertive_switch_ignored: assert property (@(posedge clk_sys) disable iff (srst)
    revertive_switch && !selMode[0] |=> curSel == $past(primary))
    else $error("revertive bit acted in a manual mode");

  chk_holdoff_wait: assert property (@(posedge clk_sys) disable iff (srst)
    autoMode && selMode == RSEL_AUTO_HOLD && !holdZero && !revertNow
      |=> curSel == $past(curSel))
    else $error("switched before hold-off expiry");

  chk_holdoff_fail: assert property (@(posedge clk_sys) disable iff (srst)
    autoMode && holdZero && !otherLos |=> curSel != $past(curSel))
    else $error("no fail-over at hold-off expiry");

  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (srst)
    $past(regAddr) == `RSEL_OFS_MODE |-> regRdData[7:5] == 3'h0 && !regRdData[1])
    else $error("reserved mode bits read non-zero");

  cov_fail_over: cover property (@(posedge clk_sys) disable iff (srst)
    autoMode && failNow ##1 curSel != $past(curSel));
  cov_revert: cover property (@(posedge clk_sys) disable iff (srst)
    autoMode && revertNow ##1 curSel == primary);
  cov_holdoff: cover property (@(posedge clk_sys) disable iff (srst) holdZero);
  cov_gated: cover property (@(posedge clk_sys) disable iff (srst) inBlock && !refAEn);
endmodule // rsel_reference_select

// File: bench/rsel_ref_source.sv
/*
  Far-side model: two reference clocks at half the system rate.
  Assumes the bench stops a clock to simulate loss of signal.
*/
`timescale 1ns/1ps
module rsel_ref_source (
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  input wire logic stopA, // silence input A
  input wire logic stopB, // silence input B
  output logic refA, // reference A level
  output logic refB // reference B level
);
  // a stopped clock parks low, as a dead source would
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      refA <= 1'b0;
      refB <= 1'b0;
    end else begin
      refA <= stopA ? 1'b0 : ~refA;
      refB <= stopB ? 1'b0 : ~refB;
    end
  end
endmodule // rsel_ref_source

// File: bench/tb_rsel_reference_select.sv
/*
  Testbench of the reference selection block: register map, gating,
  manual, automatic, revertive and hold-off selection.
  Assumes the byte register port and commit strobe of the design.
*/
`timescale 1ns/1ps
module tb_rsel_reference_select;
  import rsel_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic regWrEn = 1'b0;
  logic commitStrobe = 1'b0;
  logic stopA = 1'b0;
  logic stopB = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [1:0] extSelCfg = 2'h2;
  logic refA, refB, pllRef, refAEn, refBEn, losA, losB, holdover, holdoffExpired;
  rsel_input_type curSel;
  int fail_count = 0;
  int checks = 0;
  int n;
  logic [7:0] ofs [9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h44, 8'h45, 8'h46, 8'h47, 8'h30};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};

  always #25 clk_sys = ~clk_sys;

  rsel_ref_source u_rsel_ref_source (.clk_sys(clk_sys), .srst(srst), .stopA(stopA),
    .stopB(stopB), .refA(refA), .refB(refB));

  rsel_reference_select u_rsel_reference_select (.clk_sys(clk_sys), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
    .commitStrobe(commitStrobe), .extSelCfg(extSelCfg), .refA(refA), .refB(refB),
    .pllRef(pllRef), .refAEn(refAEn), .refBEn(refBEn), .curSel(curSel), .losA(losA),
    .losB(losB), .holdover(holdover), .holdoffExpired(holdoffExpired));

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // strobe dropped then one idle edge, so no double drive in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    tick(1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    regAddr = a;
    tick(2);
    chk(regRdData, exp, what);
  endtask

  task automatic sel(input logic [7:0] exp, input string what);
    chk({7'h00, curSel}, exp, what);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #(60000 * 50);
    fail_count++;
    tally_and_finish;
  end

  initial begin
    tick(12);
    srst = 1'b0;
    foreach (ofs[i]) rdchk(ofs[i], rv[i], "reset value");
    chk({6'h00, refAEn, refBEn}, 8'h03, "routing after reset");
    wr(8'h20, 8'hFF);
    rdchk(8'h20, 8'h05, "gating reserved");
    wr(8'h20, 8'h00);
    wr(8'h21, 8'hFF);
    rdchk(8'h21, 8'h1D, "mode reserved");
    wr(8'h23, 8'hFF);
    rdchk(8'h23, 8'hC0, "holdoff div reserved");
    wr(8'h45, 8'hFF);
    rdchk(8'h45, 8'h7F, "divider A high");
    wr(8'h47, 8'hFF);
    rdchk(8'h47, 8'h7F, "divider B high");
    wr(8'h30, 8'hFF);
    rdchk(8'h30, 8'h00, "unmapped");
    // ratio 4 gives two reference edges per monitor window
    wr(8'h44, 8'h04);
    wr(8'h45, 8'h00);
    wr(8'h46, 8'h04);
    wr(8'h47, 8'h00);
    rdchk(8'h44, 8'h04, "shadow divider");
    commitStrobe = 1'b1;
    tick(1);
    commitStrobe = 1'b0;
    tick(40);
    chk({6'h00, losA, losB}, 8'h00, "both active");
    for (int m = 0; m < 4; m++) begin
      wr(8'h21, 8'(m << 2));
      rdchk(8'h21, 8'(m << 2), "mode code");
    end
    wr(8'h20, 8'h01);
    for (int m = 0; m < 4; m += 2) begin
      wr(8'h21, 8'((m << 2) | 1));
      sel(8'h01, "manual select B");
      wr(8'h21, 8'(m << 2));
      sel(8'h00, "manual select A");
    end
    wr(8'h21, 8'h01);
    // gating only under manual selection
    wr(8'h20, 8'h05);
    chk({6'h00, refAEn, refBEn}, 8'h01, "A blocked");
    stopA = 1'b1;
    tick(40);
    chk({7'h00, losA}, 8'h00, "blocked not monitored");
    stopA = 1'b0;
    wr(8'h20, 8'h01);
    chk({6'h00, refAEn, refBEn}, 8'h03, "both routed");
    extSelCfg = 2'h0;
    wr(8'h21, 8'h04);
    stopA = 1'b1;
    tick(40);
    chk({7'h00, losA}, 8'h01, "A lost");
    sel(8'h00, "enable ignored");
    extSelCfg = 2'h2;
    tick(3);
    chk({5'h00, holdover, pllRef, curSel}, {6'h00, ~refB, 1'b1}, "auto fail-over");
    stopA = 1'b0;
    tick(40);
    chk({7'h00, losA}, 8'h00, "A back");
    sel(8'h01, "no revert");
    wr(8'h21, 8'h14);
    tick(3);
    sel(8'h00, "revert to primary");
    stopB = 1'b1;
    tick(40);
    chk({7'h00, losB}, 8'h01, "B lost");
    sel(8'h00, "stay on primary");
    stopB = 1'b0;
    tick(40);
    // shortest prescale and period keep the wait near 32768 cycles
    wr(8'h23, 8'h00);
    wr(8'h22, 8'h00);
    wr(8'h21, 8'h0C);
    stopA = 1'b1;
    tick(100);
    chk({5'h00, holdover, pllRef, curSel}, 8'h04, "held during countdown");
    n = 100;
    while (holdoffExpired !== 1'b1 && n < 34000) begin
      tick(1);
      n++;
    end
    chk({7'h00, n < 34000}, 8'h01, "hold-off expiry");
    tick(2);
    sel(8'h01, "fail-over on expiry");
    tally_and_finish;
  end
endmodule // tb_rsel_reference_select
